// *** rtl/mcrf_cfg.svh ***
/*
  constants of the core register file: page offsets, field positions,
  reset values and widths. assumes nothing; definitions only.
*/
`ifndef MCRF_CFG_SVH
`define MCRF_CFG_SVH
`define MCRF_ADR_INDIRECT  6'h00
`define MCRF_ADR_TIMER     6'h01
`define MCRF_ADR_PC        6'h02
`define MCRF_ADR_STATUS    6'h03
`define MCRF_ADR_RAMSEL    6'h04
`define MCRF_ADR_PORT5     6'h05
`define MCRF_ADR_PORT6     6'h06
`define MCRF_ADR_PULLDN    6'h0b
`define MCRF_ADR_OPENDR    6'h0c
`define MCRF_ADR_PULLHI    6'h0d
`define MCRF_ADR_WDOG      6'h0e
`define MCRF_ADR_INTFLAG   6'h0f
`define MCRF_ADR_GP_LO     6'h10
`define MCRF_ADR_GP_HI     6'h2f
`define MCRF_GP_DEPTH      32
`define MCRF_PC_W          10
`define MCRF_PC_LOW_W      8
`define MCRF_STACK_DEPTH   5
`define MCRF_SP_W          3
`define MCRF_CTL_EDGE      4
`define MCRF_CTL_SOURCE    5
`define MCRF_CTL_ASSIGN    3
`define MCRF_ST_RST        7
`define MCRF_ST_TO         4
`define MCRF_ST_PD         3
`define MCRF_ST_Z          2
`define MCRF_ST_DC         1
`define MCRF_ST_C          0
`define MCRF_WDG_EIS       6
`define MCRF_IF_EXT        2
`define MCRF_RAMSEL_FIXED  8'hc0
`define MCRF_CTL_RESET     8'h3f
`define MCRF_STATUS_RESET  8'h18
`define MCRF_ZERO8         8'h00
`endif

// *** rtl/mcrf_pkg.sv ***
/*
  types of the core register file.
  assumes mcrf_cfg.svh for widths.
*/
`include "mcrf_cfg.svh"
package mcrf_pkg;
  // one instruction-stream access to the data memory
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       ctlPage;
    logic [5:0] addr;
    logic [7:0] wdata;
  } mcrf_acc_t;
  // flow control requests from the decoder
  typedef struct packed {
    logic       jump;
    logic       call;
    logic       ret;
    logic       advance;
    logic [9:0] target;
  } mcrf_flow_t;
  // status events from the alu and power logic
  typedef struct packed {
    logic aluValid;
    logic zero;
    logic halfCarry;
    logic carry;
    logic sleepOp;
    logic wdogClearOp;
    logic wdogTimeout;
    logic pinWake;
  } mcrf_evt_t;
  typedef enum logic {MCRF_EXEC, MCRF_FLUSH} mcrf_phase_t;
endpackage

// *** rtl/mcrf_stack.sv ***
/*
  five-entry return stack, ten bits per entry; full push drops oldest.
  assumes push and pop never coincide, caller on sys_clk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "mcrf_cfg.svh"
module mcrf_stack (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  // stack operations
  input  wire logic                   push,
  input  wire logic                   pop,
  input  wire logic [`MCRF_PC_W-1:0]  pushData,
  output logic      [`MCRF_PC_W-1:0]  topData
);
  typedef struct packed {
    logic [`MCRF_STACK_DEPTH-1:0][`MCRF_PC_W-1:0] entry;
  } mcrf_stk_t;
  mcrf_stk_t st, next_st;
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.entry = {st.entry[`MCRF_STACK_DEPTH-2:0], pushData};
    end else if (pop) begin
      next_st.entry = {st.entry[0], st.entry[`MCRF_STACK_DEPTH-1:1]};
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign topData = st.entry[0];
  pushTop_a: assert property (@(posedge sys_clk) disable iff (reset)
    push |=> topData == $past(pushData)) else $error("push not on top");
endmodule // mcrf_stack
`default_nettype wire

// *** rtl/mcrf_core_regs.sv ***
/*
  operational and control register pages, general storage, timer with
  prescaler, program counter and status of a small 8-bit core.
  assumes one instruction-stream client on sys_clk, one access per
  instruction cycle enable; pins are asynchronous.
*/
// Function
// - indirect location redirects through ram select
// - timer counts pin edge or cycle
// - assign bit clear gives prescaler to timer
// - only timer write clears prescaler
// - pc and stack entries ten bits
// - one page of 1024 instruction words
// - jump loads lower ten pc bits
// - call loads target, pushes next address
// - returns reload pc from stack top
// - data write to pc clears upper bits
// - one cycle, pc changes add one
// - two pages plus general storage decoded
// - status bit 7 marks pin-change wake
// - status bits 6,5 free storage
// - time-out bit set/cleared by events
// - power-down bit set/cleared by events
// - zero, half carry, carry from alu
// - ram select low six bits address
// - interrupt pin requests on falling edge
// - reset-shared pin input only, wakes
// - return stack five entries deep
`timescale 1ns/1ns
`default_nettype none
`include "mcrf_cfg.svh"
module mcrf_core_regs (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  // instruction cycle select: high gives fclk/4
  input  wire logic                  slowCycle,
  // instruction stream
  input  wire mcrf_pkg::mcrf_acc_t   acc,
  input  wire mcrf_pkg::mcrf_flow_t  flow,
  input  wire mcrf_pkg::mcrf_evt_t   evt,
  output logic      [7:0]            rdata,
  output logic      [`MCRF_PC_W-1:0] progAddr,
  output logic                       cycleEn,
  output logic                       flushCycle,
  // pins
  input  wire logic                  timer_count_input,
  input  wire logic                  extIntPin,
  input  wire logic                  reset_shared_input_pin,
  output logic                       extIntRequest,
  output logic                       wakeRequest,
  // control outputs to port, timer, interrupt and watchdog logic
  output logic      [7:0]            port_five_direction,
  output logic      [7:0]            port_six_direction,
  output logic      [7:0]            pull_down_control,
  output logic      [7:0]            open_drain_control,
  output logic      [7:0]            pull_high_control,
  output logic      [7:0]            watchdog_control,
  output logic      [7:0]            interrupt_mask_bits,
  output logic      [7:0]            timer_prescaler_control,
  output logic                       prescalerToWatchdog
);
  typedef struct packed {
    logic [1:0]                div;
    mcrf_pkg::mcrf_phase_t     phase;
    logic [`MCRF_PC_W-1:0]     pc;
    logic [7:0]                timer;
    logic [7:0]                presc;
    logic [7:0]                status;
    logic [5:0]                ramSel;
    logic [7:0]                ctl;
    logic [7:0]                dir5;
    logic [7:0]                dir6;
    logic [7:0]                pdn;
    logic [7:0]                odr;
    logic [7:0]                phi;
    logic [7:0]                wdg;
    logic [7:0]                imask;
    logic [7:0]                iflag;
    logic [1:0]                tccSync;
    logic [1:0]                intSync;
    logic [1:0]                rstSync;
    logic                      tccLast;
    logic                      intLast;
    logic                      rstLast;
    logic                      pendExt;
    logic                      pendWake;
    logic [2:0]                warm;
    logic [7:0]                rdata;
  } mcrf_state_t;
  mcrf_state_t s, next_s;
  logic [7:0] gpMem [`MCRF_GP_DEPTH];
  logic [5:0] effAddr;
  logic       gpHit;
  logic [`MCRF_PC_W-1:0] stackTop;
  logic       doPush;
  logic       doPop;
  logic [7:0] rd;
  logic       tccEdge;
  logic       timerTick;
  logic       wrOp;
  logic       wrCtl;
  logic [`MCRF_PC_W-1:0] pcInc;
  logic       pcRedirect;
  logic       timerWr;

  // indirect access uses ram select low bits
  assign effAddr = (!acc.ctlPage && acc.addr == `MCRF_ADR_INDIRECT) ? s.ramSel : acc.addr;
  assign gpHit   = effAddr >= `MCRF_ADR_GP_LO && effAddr <= `MCRF_ADR_GP_HI;
  assign wrOp    = cycleEn && s.phase == mcrf_pkg::MCRF_EXEC && acc.wr && !acc.ctlPage;
  assign wrCtl   = cycleEn && s.phase == mcrf_pkg::MCRF_EXEC && acc.wr && acc.ctlPage;
  assign pcInc   = s.pc + `MCRF_PC_W'(1);
  assign doPush  = cycleEn && s.phase == mcrf_pkg::MCRF_EXEC && flow.call;
  assign doPop   = cycleEn && s.phase == mcrf_pkg::MCRF_EXEC && flow.ret;
  assign tccEdge = s.ctl[`MCRF_CTL_EDGE] ? (s.tccLast && !s.tccSync[1])
                                        : (!s.tccLast && s.tccSync[1]);
  // no pin tick while the synchronisers still hold reset levels
  assign timerTick = s.ctl[`MCRF_CTL_SOURCE] ? (tccEdge && &s.warm)
                   : (cycleEn && s.phase == mcrf_pkg::MCRF_EXEC);
  assign pcRedirect = flow.jump || flow.call || flow.ret
                   || (wrOp && effAddr == `MCRF_ADR_PC);
  assign timerWr = wrOp && effAddr == `MCRF_ADR_TIMER;

  mcrf_stack u_stack (
    .sys_clk (sys_clk),
    .reset   (reset),
    .push    (doPush),
    .pop     (doPop),
    .pushData(pcInc),
    .topData (stackTop)
  );

  // read decode per page; reserved reads as zero
  always_comb begin
    rd = `MCRF_ZERO8;
    if (acc.ctlPage) begin
      case (acc.addr)
        `MCRF_ADR_TIMER:   rd = s.ctl;
        `MCRF_ADR_PORT5:   rd = s.dir5;
        `MCRF_ADR_PORT6:   rd = s.dir6;
        `MCRF_ADR_PULLDN:  rd = s.pdn;
        `MCRF_ADR_OPENDR:  rd = s.odr;
        `MCRF_ADR_PULLHI:  rd = s.phi;
        `MCRF_ADR_WDOG:    rd = s.wdg;
        `MCRF_ADR_INTFLAG: rd = s.imask;
        default:           rd = `MCRF_ZERO8;
      endcase
    end else if (gpHit) begin
      rd = gpMem[effAddr[4:0]];
    end else begin
      case (effAddr)
        `MCRF_ADR_TIMER:   rd = s.timer;
        `MCRF_ADR_PC:      rd = s.pc[`MCRF_PC_LOW_W-1:0];
        `MCRF_ADR_STATUS:  rd = s.status;
        `MCRF_ADR_RAMSEL:  rd = `MCRF_RAMSEL_FIXED | {2'h0, s.ramSel};
        `MCRF_ADR_INTFLAG: rd = s.iflag & s.imask;
        default:           rd = `MCRF_ZERO8;
      endcase
    end
  end

  always_comb begin
    next_s = s;
    next_s.div = s.div + 2'h1;
    // pin synchronisers; only stage 1 is looked at
    next_s.tccSync = {s.tccSync[0], timer_count_input};
    next_s.intSync = {s.intSync[0], extIntPin};
    next_s.rstSync = {s.rstSync[0], reset_shared_input_pin};
    next_s.tccLast = s.tccSync[1];
    next_s.intLast = s.intSync[1];
    next_s.rstLast = s.rstSync[1];
    // edge detectors wait until the pin pipeline holds real levels
    next_s.warm     = {s.warm[1:0], 1'b1};
    next_s.pendExt  = &s.warm && s.intLast && !s.intSync[1]
                      && s.wdg[`MCRF_WDG_EIS];
    next_s.pendWake = &s.warm && s.rstLast != s.rstSync[1];
    if (acc.rd) begin
      next_s.rdata = rd;
    end
    // prescaler on timer when assign bit is clear
    if (!s.ctl[`MCRF_CTL_ASSIGN] && timerTick) begin
      next_s.presc = s.presc + 8'h01;
    end
    if (timerTick) begin
      next_s.timer = s.timer + 8'h01;
    end
    // pc change costs one flush cycle
    if (cycleEn) begin
      if (s.phase == mcrf_pkg::MCRF_FLUSH) begin
        next_s.phase = mcrf_pkg::MCRF_EXEC;
      end else begin
        if (pcRedirect) begin
          next_s.phase = mcrf_pkg::MCRF_FLUSH;
        end
        if (flow.jump || flow.call) begin
          next_s.pc = flow.target;
        end else if (flow.ret) begin
          next_s.pc = stackTop;
        end else if (flow.advance) begin
          next_s.pc = pcInc;
        end
      end
    end
    // status events: alu flags, sleep and watchdog bits
    if (evt.aluValid) begin
      next_s.status[`MCRF_ST_Z]  = evt.zero;
      next_s.status[`MCRF_ST_DC] = evt.halfCarry;
      next_s.status[`MCRF_ST_C]  = evt.carry;
    end
    if (wrOp) begin
      case (effAddr)
        `MCRF_ADR_TIMER: begin
          next_s.timer = acc.wdata;
          next_s.presc = `MCRF_ZERO8;
        end
        `MCRF_ADR_PC:      next_s.pc = {2'h0, acc.wdata};
        `MCRF_ADR_STATUS:  next_s.status[6:0] = {acc.wdata[6:5], s.status[4:3],
                                                 acc.wdata[2:0]};
        `MCRF_ADR_RAMSEL:  next_s.ramSel = acc.wdata[5:0];
        `MCRF_ADR_INTFLAG: next_s.iflag = s.iflag & acc.wdata; // clear only
        default:           next_s.ramSel = s.ramSel;
      endcase
    end
    if (s.pendExt) begin
      next_s.iflag[`MCRF_IF_EXT] = 1'b1; // set beats a same-cycle clear
    end
    if (evt.wdogTimeout) begin
      next_s.status[`MCRF_ST_TO] = 1'b0;
    end
    if (evt.sleepOp) begin
      next_s.status[`MCRF_ST_TO] = 1'b1;
      next_s.status[`MCRF_ST_PD] = 1'b0;
    end
    if (evt.wdogClearOp) begin
      next_s.status[`MCRF_ST_TO] = 1'b1;
      next_s.status[`MCRF_ST_PD] = 1'b1;
    end
    if (evt.pinWake) begin
      next_s.status[`MCRF_ST_RST] = 1'b1;
    end
    if (wrCtl) begin
      case (acc.addr)
        `MCRF_ADR_TIMER:   next_s.ctl = acc.wdata;
        `MCRF_ADR_PORT5:   next_s.dir5 = acc.wdata;
        `MCRF_ADR_PORT6:   next_s.dir6 = acc.wdata;
        `MCRF_ADR_PULLDN:  next_s.pdn = acc.wdata;
        `MCRF_ADR_OPENDR:  next_s.odr = acc.wdata;
        `MCRF_ADR_PULLHI:  next_s.phi = acc.wdata;
        `MCRF_ADR_WDOG:    next_s.wdg = acc.wdata;
        `MCRF_ADR_INTFLAG: next_s.imask = acc.wdata;
        default:           next_s.ctl = s.ctl;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s <= '0; // pc zero, reset-type bit zero
      s.status <= `MCRF_STATUS_RESET;
      s.ctl    <= `MCRF_CTL_RESET;
    end else begin
      s <= next_s;
    end
  end

  // general storage, no reset needed
  always_ff @(posedge sys_clk) begin
    if (wrOp && gpHit) begin
      gpMem[effAddr[4:0]] <= acc.wdata;
    end
  end

  assign cycleEn  = slowCycle ? (s.div == 2'h3) : s.div[0];
  assign flushCycle = s.phase == mcrf_pkg::MCRF_FLUSH;
  assign rdata    = s.rdata;
  assign progAddr = s.pc;
  assign extIntRequest = s.iflag[`MCRF_IF_EXT];
  assign wakeRequest   = s.pendWake;
  assign port_five_direction = s.dir5;
  assign port_six_direction  = s.dir6;
  assign pull_down_control   = s.pdn;
  assign open_drain_control  = s.odr;
  assign pull_high_control   = s.phi;
  assign watchdog_control    = s.wdg;
  assign interrupt_mask_bits = s.imask;
  assign timer_prescaler_control = s.ctl;
  assign prescalerToWatchdog = s.ctl[`MCRF_CTL_ASSIGN];

  jumpLoad_a: assert property (@(posedge sys_clk) disable iff (reset)
    cycleEn && !flushCycle && flow.jump |=> progAddr == $past(flow.target))
    else $error("jump target not loaded");
  callLoad_a: assert property (@(posedge sys_clk) disable iff (reset)
    cycleEn && !flushCycle && flow.call && !flow.jump && !wrOp
    |=> progAddr == $past(flow.target))
    else $error("call target not loaded");
  retLoad_a: assert property (@(posedge sys_clk) disable iff (reset)
    cycleEn && !flushCycle && flow.ret && !flow.jump && !flow.call && !wrOp
    |=> progAddr == $past(stackTop))
    else $error("return address not loaded");
  pcWrite_a: assert property (@(posedge sys_clk) disable iff (reset)
    wrOp && effAddr == `MCRF_ADR_PC && !flow.jump && !flow.call && !flow.ret
    |=> progAddr[9:8] == 2'h0 && flushCycle)
    else $error("pc write kept upper bits");
  presClear_a: assert property (@(posedge sys_clk) disable iff (reset)
    !$past(reset) && s.presc == 8'h00 && $past(s.presc) != 8'h00
    && $past(s.presc) != 8'hff |-> $past(timerWr))
    else $error("prescaler cleared without timer write");
  presCount_a: assert property (@(posedge sys_clk) disable iff (reset)
    !s.ctl[`MCRF_CTL_ASSIGN] && timerTick && !timerWr
    |=> s.presc == $past(s.presc) + 8'h01)
    else $error("prescaler not on timer");
  presIdle_a: assert property (@(posedge sys_clk) disable iff (reset)
    s.ctl[`MCRF_CTL_ASSIGN] && !timerWr |=> $stable(s.presc))
    else $error("prescaler moved while on watchdog");
  timerWrite_a: assert property (@(posedge sys_clk) disable iff (reset)
    timerWr |=> s.timer == $past(acc.wdata))
    else $error("timer write lost");
  resvRead_a: assert property (@(posedge sys_clk) disable iff (reset)
    acc.rd && acc.ctlPage && acc.addr == `MCRF_ADR_PC |=> rdata == 8'h00)
    else $error("reserved location read nonzero");
  flushOne_a: assert property (@(posedge sys_clk) disable iff (reset)
    flushCycle && cycleEn |=> !flushCycle)
    else $error("flush lasted too long");
  sleepBits_a: assert property (@(posedge sys_clk) disable iff (reset)
    evt.sleepOp && !evt.wdogClearOp |=> s.status[4:3] == 2'b10)
    else $error("sleep bits wrong");
  clearBits_a: assert property (@(posedge sys_clk) disable iff (reset)
    evt.wdogClearOp |=> s.status[`MCRF_ST_TO] && s.status[`MCRF_ST_PD])
    else $error("watchdog clear bits wrong");
  timeoutBit_a: assert property (@(posedge sys_clk) disable iff (reset)
    evt.wdogTimeout && !evt.sleepOp && !evt.wdogClearOp |=> !s.status[`MCRF_ST_TO])
    else $error("time-out bit not cleared");
  aluFlags_a: assert property (@(posedge sys_clk) disable iff (reset)
    evt.aluValid && !wrOp |=> s.status[`MCRF_ST_Z] == $past(evt.zero)
    && s.status[`MCRF_ST_DC] == $past(evt.halfCarry)
    && s.status[`MCRF_ST_C] == $past(evt.carry))
    else $error("alu flags not taken");
  ramselRead_a: assert property (@(posedge sys_clk) disable iff (reset)
    acc.rd && !acc.ctlPage && acc.addr == `MCRF_ADR_RAMSEL
    |=> rdata[7:6] == 2'b11)
    else $error("ram select upper bits not one");
  intEdge_a: assert property (@(posedge sys_clk) disable iff (reset)
    &s.warm && s.intLast && !s.intSync[1] && s.wdg[`MCRF_WDG_EIS] ##1 1'b1
    |=> extIntRequest)
    else $error("falling edge missed");
  wakeMark_a: assert property (@(posedge sys_clk) disable iff (reset)
    evt.pinWake |=> s.status[7])
    else $error("wake type not marked");
endmodule // mcrf_core_regs
`default_nettype wire

// *** verification/mcrf_core_regs_tb_top.sv ***
/*
  self-checking bench of the core register file: map, pointer, status,
  timer, flow, cycle and pin scenarios driven through the instruction port, cycle select and pins.
  assumes the design package and modules are compiled before it.
*/
`timescale 1ns/1ns
`default_nettype none
module mcrf_core_regs_tb_top;
  logic                 sys_clk   = 1'b0;
  logic                 reset     = 1'b1;
  logic                 slowCycle = 1'b0;
  mcrf_pkg::mcrf_acc_t  acc       = '0;
  mcrf_pkg::mcrf_flow_t flow      = '0;
  mcrf_pkg::mcrf_evt_t  evt       = '0;
  logic                 tcPin     = 1'b0;
  logic                 intPin    = 1'b1;
  logic                 rstPin    = 1'b1;
  logic [7:0]           rdata, p5Dir, p6Dir, pdCtl, odCtl, phCtl, wdCtl, imCtl, tpCtl;
  logic [9:0]           progAddr;
  logic                 cycleEn, flushCycle, extIntRequest, wakeRequest, toWdog;
  logic [7:0]           rv;
  int                   miscompares = 0;
  int                   compares    = 0;
  int                   n;
  // event pulse, status mask and expected status bits
  logic [7:0]           evTab [0:5] = '{8'h08, 8'h02, 8'h04, 8'hd0, 8'ha0, 8'h01};
  logic [7:0]           mkTab [0:5] = '{8'h18, 8'h10, 8'h18, 8'h07, 8'h07, 8'h80};
  logic [7:0]           exTab [0:5] = '{8'h10, 8'h00, 8'h18, 8'h05, 8'h02, 8'h80};

  always #20 sys_clk = ~sys_clk;

  mcrf_core_regs i_dut (
    .sys_clk                 (sys_clk),
    .reset                   (reset),
    .slowCycle               (slowCycle),
    .acc                     (acc),
    .flow                    (flow),
    .evt                     (evt),
    .rdata                   (rdata),
    .progAddr                (progAddr),
    .cycleEn                 (cycleEn),
    .flushCycle              (flushCycle),
    .timer_count_input       (tcPin),
    .extIntPin               (intPin),
    .reset_shared_input_pin  (rstPin),
    .extIntRequest           (extIntRequest),
    .wakeRequest             (wakeRequest),
    .port_five_direction     (p5Dir),
    .port_six_direction      (p6Dir),
    .pull_down_control       (pdCtl),
    .open_drain_control      (odCtl),
    .pull_high_control       (phCtl),
    .watchdog_control        (wdCtl),
    .interrupt_mask_bits     (imCtl),
    .timer_prescaler_control (tpCtl),
    .prescalerToWatchdog     (toWdog)
  );

  task automatic chk8(input string w, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic chk10(input string w, input logic [9:0] e, input logic [9:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic chk1(input string w, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %b seen %b", w, e, g);
    end
  endtask

  // cycleEn is looked at mid-cycle so the accepting edge is known in advance
  task automatic take;
    for (int i = 0; i < 32; i++) begin
      @(negedge sys_clk);
      if (cycleEn === 1'b1 && flushCycle === 1'b0) break;
    end
    @(posedge sys_clk);
    #1;
  endtask

  task automatic wait4;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic ctl, input logic [5:0] a, input logic [7:0] d);
    acc = '{1'b0, 1'b1, ctl, a, d};
    take();
    acc = '0;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic rd(input logic ctl, input logic [5:0] a);
    acc = '{1'b1, 1'b0, ctl, a, 8'h00};
    take();
    rv = rdata;
    acc = '0;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic go(input logic j, c, r, input logic [9:0] t, e);
    flow = '{j, c, r, 1'b0, t};
    take();
    flow = '0;
    chk10("progAddr", e, progAddr);
    chk1("flushCycle", 1'b1, flushCycle);
    @(posedge sys_clk);
    #1;
  endtask

  task automatic complete_run;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // generous bound: the sequence needs well under a tenth of it
  initial begin
    #2000000;
    miscompares++;
    complete_run();
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    chk10("progAddr", 10'h000, progAddr);
    // the idle-high shared pin must not look like a change after reset
    n = 0;
    repeat (8) begin
      @(negedge sys_clk);
      if (wakeRequest === 1'b1) n++;
    end
    chk8("wakesReset", 8'h00, 8'(n));
    @(posedge sys_clk);
    #1;
    rd(1'b0, 6'h03);
    chk8("status", 8'h18, rv);
    $display("test reset done");

    wr(1'b0, 6'h10, 8'h3c);
    wr(1'b0, 6'h2f, 8'hc3);
    wr(1'b0, 6'h07, 8'h77);
    rd(1'b0, 6'h10);
    chk8("gp10", 8'h3c, rv);
    rd(1'b0, 6'h07);
    chk8("reserved", 8'h00, rv);
    rd(1'b1, 6'h02);
    chk8("ctlReserved", 8'h00, rv);
    wr(1'b1, 6'h06, 8'ha5);
    rd(1'b1, 6'h06);
    chk8("p6DirRead", 8'ha5, rv);
    chk8("p6Dir", 8'ha5, p6Dir);
    wr(1'b1, 6'h05, 8'h0a);
    wr(1'b1, 6'h0b, 8'h88);
    wr(1'b1, 6'h0c, 8'hf7);
    wr(1'b1, 6'h0d, 8'h08);
    wr(1'b1, 6'h0f, 8'hfc);
    chk8("p5Dir", 8'h0a, p5Dir);
    chk8("pdCtl", 8'h88, pdCtl);
    chk8("odCtl", 8'hf7, odCtl);
    chk8("phCtl", 8'h08, phCtl);
    chk8("imCtl", 8'hfc, imCtl);
    wr(1'b0, 6'h04, 8'h10);
    rd(1'b0, 6'h04);
    chk8("ramSel", 8'hd0, rv);
    rd(1'b0, 6'h00);
    chk8("indirect", 8'h3c, rv);
    wr(1'b0, 6'h00, 8'h5a);
    rd(1'b0, 6'h10);
    chk8("gp10", 8'h5a, rv);
    wr(1'b0, 6'h04, 8'h2f);
    rd(1'b0, 6'h04);
    chk8("ramSel", 8'hef, rv);
    rd(1'b0, 6'h00);
    chk8("indirect", 8'hc3, rv);
    $display("test map done");

    wr(1'b0, 6'h03, 8'h60);
    rd(1'b0, 6'h03);
    chk8("scratch", 8'h60, rv & 8'h60);
    wr(1'b0, 6'h03, 8'h20);
    rd(1'b0, 6'h03);
    chk8("scratch", 8'h20, rv & 8'h60);
    for (int i = 0; i < 6; i++) begin
      evt = mcrf_pkg::mcrf_evt_t'(evTab[i]);
      @(posedge sys_clk);
      #1;
      evt = '0;
      rd(1'b0, 6'h03);
      chk8("statusEvt", exTab[i], rv & mkTab[i]);
    end
    $display("test status done");

    // one counted edge per toggle pair, for both edge selections
    for (int e = 0; e < 2; e++) begin
      tcPin = e[0];
      wr(1'b1, 6'h01, {3'b001, e[0], 4'h0});
      chk1("toWdog", 1'b0, toWdog);
      wr(1'b0, 6'h01, 8'h00);
      repeat (3) begin
        tcPin = ~tcPin;
        wait4();
        tcPin = ~tcPin;
        wait4();
      end
      rd(1'b0, 6'h01);
      chk8("timer", 8'h03, rv);
    end
    wr(1'b1, 6'h01, 8'h08);
    chk1("toWdog", 1'b1, toWdog);
    chk8("tpCtl", 8'h08, tpCtl);
    // cycle source: fclk/2 gives one tick per two clocks
    wr(1'b0, 6'h01, 8'h00);
    wait4();
    rd(1'b0, 6'h01);
    chk8("timerCycles", 8'h02, rv);
    $display("test timer done");

    go(1'b1, 1'b0, 1'b0, 10'h3ff, 10'h3ff);
    wr(1'b0, 6'h02, 8'hab);
    chk10("pcWrite", 10'h0ab, progAddr);
    go(1'b1, 1'b0, 1'b0, 10'h100, 10'h100);
    // six calls into five entries: the first return address is lost
    for (int i = 0; i < 6; i++) begin
      go(1'b0, 1'b1, 1'b0, 10'h200 + 10'(16 * i), 10'h200 + 10'(16 * i));
    end
    for (int i = 0; i < 5; i++) begin
      go(1'b0, 1'b0, 1'b1, 10'h000, 10'h241 - 10'(16 * i));
    end
    flow = '{1'b0, 1'b0, 1'b0, 1'b1, 10'h000};
    take();
    flow = '0;
    chk10("advance", 10'h202, progAddr);
    $display("test flow done");

    for (int s = 0; s < 2; s++) begin
      slowCycle = s[0];
      repeat (8) @(posedge sys_clk);
      n = 0;
      repeat (16) begin
        @(negedge sys_clk);
        if (cycleEn === 1'b1) n++;
      end
      chk8("cycles", s ? 8'h04 : 8'h08, 8'(n));
      @(posedge sys_clk);
      #1;
    end
    slowCycle = 1'b0;
    $display("test cycle done");

    wr(1'b1, 6'h0e, 8'h40);
    chk8("wdCtl", 8'h40, wdCtl);
    intPin = 1'b0;
    wait4();
    chk1("extInt", 1'b1, extIntRequest);
    intPin = 1'b1;
    rd(1'b0, 6'h0f);
    chk8("intFlags", 8'h04, rv);
    wr(1'b0, 6'h0f, 8'h00);
    chk1("extInt", 1'b0, extIntRequest);
    rstPin = 1'b0;
    n = 0;
    repeat (8) begin
      @(negedge sys_clk);
      if (wakeRequest === 1'b1) n++;
    end
    chk8("wakes", 8'h01, 8'(n));
    @(posedge sys_clk);
    #1;
    $display("test pins done");

    go(1'b1, 1'b0, 1'b0, 10'h155, 10'h155);
    reset = 1'b1;
    #1;
    chk10("progAddr", 10'h000, progAddr);
    repeat (3) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    rd(1'b0, 6'h03);
    chk8("statusReset", 8'h18, rv);
    $display("test second reset done");
    complete_run();
  end
endmodule // mcrf_core_regs_tb_top
`default_nettype wire
